/* File: flash_prot_pkg.sv */
/*
  shared constants and carriers for the flash row protection checker.
  assumes one 100 mhz clock and a synchronous active-low reset.
*/
package flash_prot_pkg;
  localparam int ROW_BYTES      = 256;        // data bytes per row
  localparam int ROW_ECC_BYTES  = 32;         // ecc/config bytes per row
  localparam int ROW_COUNT      = 256;        // rows in largest array
  localparam int ROW_BITS       = 8;          // row index width
  localparam int BYTE_BITS      = 8;          // byte offset width in a row
  localparam int ADDR_BITS      = ROW_BITS + BYTE_BITS; // 16-bit address
  localparam int DATA_BITS      = 8;          // data width
  localparam int ECC_ADDR_BITS  = 5;          // offset inside ecc part

  // two-bit protection code per row
  typedef enum logic [1:0] {
    PROT_OPEN    = 2'h0,                      // unprotected
    PROT_FACTORY = 2'h1,                      // factory upgrade
    PROT_FIELD   = 2'h2,                      // field upgrade
    PROT_FULL    = 2'h3                       // full protection
  } prot_level_t;

  localparam prot_level_t PROT_RESET = PROT_OPEN; // level after erase

  // one access request
  typedef struct packed {
    logic                   valid;            // request present
    logic                   external;         // from debug/program port
    logic                   write;            // write when set
    logic [ADDR_BITS-1:0]   addr;             // row and byte
    logic [DATA_BITS-1:0]   wdata;            // write data
  } access_req_t;

  // answer to a request
  typedef struct packed {
    logic                   valid;            // answer present
    logic                   violation;        // access refused
    logic [DATA_BITS-1:0]   rdata;            // read data, zero if refused
  } access_rsp_t;

  // protection programming request, honoured only during full erase
  typedef struct packed {
    logic                   valid;            // set-level request
    logic [ROW_BITS-1:0]    row;              // target row
    prot_level_t            level;            // new level
  } prot_set_t;

  // checker sequence states, gray along idle-erase-prog
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,                         // normal accesses
    ST_ERASE = 2'b01,                         // array being cleared
    ST_PROG  = 2'b11                          // levels may be loaded
  } chk_state_t;
endpackage

/* File: prot_decide.sv */
/*
  combinational permission decision for one access against a row level.
  assumes level and request are stable in the same cycle.
*/
module prot_decide (
  input  wire flash_prot_pkg::prot_level_t level_in,    // row level
  input  wire logic                        external_in, // external source
  input  wire logic                        write_in,    // write access
  input  wire logic                        secured_in,  // ports shut off
  output logic                             allow_out    // access granted
);
  ////////////////////////////////////////////////////////////////////////
  // permission table per level
  always_comb
  begin
    allow_out = 1'b0;
    case (level_in)
      flash_prot_pkg::PROT_OPEN:    allow_out = 1'b1;
      flash_prot_pkg::PROT_FACTORY:
      begin
        // everything but an external read
        allow_out = !(external_in && !write_in);
      end
      flash_prot_pkg::PROT_FIELD:   allow_out = !external_in;
      flash_prot_pkg::PROT_FULL:
      begin
        // internal reads only
        allow_out = !external_in && !write_in;
      end
      default:                      allow_out = 1'b0;
    endcase
    if (external_in && secured_in)
    begin
      allow_out = 1'b0;
    end
  end
endmodule // prot_decide

/* File: flash_row_protection_checker.sv */
/*
  flash row protection checker: holds the flash array and a level per row,
  grants or refuses accesses, and handles full erase and device security.
  assumes requests are synchronous to core_clk_in; one answer per request,
  one cycle later, except a request in the cycle that starts an erase.
*/
// Function
// - rows of 256 bytes plus 32 ecc, 256
// - separate four-level protection per flash row
// - level changes only during full erase
// - unprotected allows all reads and writes
// - factory upgrade refuses external reads only
// - field upgrade allows internal access only
// - full protection allows internal reads only
// - field and full block external tool access
// - device security disables external ports until a system reset
module flash_row_protection_checker (
  input  wire logic                        core_clk_in,   // system clock
  input  wire logic                        rst_b_in,      // sync reset, low
  input  wire flash_prot_pkg::access_req_t req_in,        // access request
  input  wire logic                        erase_in,      // start full erase
  input  wire flash_prot_pkg::prot_set_t   prot_set_in,   // level load
  input  wire logic                        prog_done_in,  // end level load
  input  wire logic                        secure_in,     // engage security
  output flash_prot_pkg::access_rsp_t      rsp_out,       // access answer
  output logic                             busy_out,      // erase/prog phase
  output logic                             secured_out,   // ports disabled
  output logic                             prot_reject_out // level set refused
);
  ////////////////////////////////////////////////////////////////////////
  // storage
  logic [flash_prot_pkg::DATA_BITS-1:0] mem [flash_prot_pkg::ROW_COUNT*
                                              flash_prot_pkg::ROW_BYTES];
  logic [flash_prot_pkg::DATA_BITS-1:0] ecc_mem [flash_prot_pkg::ROW_COUNT*
                                              flash_prot_pkg::ROW_ECC_BYTES];
  flash_prot_pkg::prot_level_t level [flash_prot_pkg::ROW_COUNT];

  flash_prot_pkg::chk_state_t state;         // sequence state
  flash_prot_pkg::chk_state_t next_state;    // next sequence state
  logic [flash_prot_pkg::ROW_BITS-1:0] erase_row;      // erase walker
  logic [flash_prot_pkg::ROW_BITS-1:0] next_erase_row; // next walker
  logic                                secured;        // security latch
  logic                                next_secured;   // next latch
  flash_prot_pkg::access_rsp_t         next_rsp;       // next answer
  logic                                next_reject;    // next reject flag
  logic                                allow;          // decision result
  logic                                do_write;       // grant write
  logic [flash_prot_pkg::ROW_BITS-1:0] req_row;        // request row
  logic                                next_busy;      // next busy level

  // index of the final row that the erase walker clears
  localparam logic [flash_prot_pkg::ROW_BITS-1:0] LAST_ROW =
    flash_prot_pkg::ROW_BITS'(flash_prot_pkg::ROW_COUNT - 1);

  // row part of the address picks the level entry; the level table sits
  // in flops so the decision settles well inside the cycle
  assign req_row = req_in.addr[flash_prot_pkg::ADDR_BITS-1:
                               flash_prot_pkg::BYTE_BITS];

  ////////////////////////////////////////////////////////////////////////
  // permission decision
  // secured shuts every external source whatever the row level
  prot_decide u_decide (
    .level_in    (level[req_row]),
    .external_in (req_in.external),
    .write_in    (req_in.write),
    .secured_in  (secured),
    .allow_out   (allow)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequence, security and answer next values
  always_comb
  begin
    // defaults: stay put, no answer, no reject, no write
    next_state     = state;
    next_erase_row = erase_row;
    next_secured   = secured | secure_in;
    next_reject    = 1'b0;
    next_rsp       = '0;
    do_write       = 1'b0;
    case (state)
      flash_prot_pkg::ST_IDLE:
      begin
        if (erase_in)
        begin
          // erase wins; a request in the same cycle gets no answer
          next_state     = flash_prot_pkg::ST_ERASE;
          next_erase_row = '0;
        end
        else if (req_in.valid)
        begin
          // refused access leaves flash alone, zero data, flag raised
          next_rsp.valid     = 1'b1;
          next_rsp.violation = !allow;
          // read returns the byte as it stood before this edge
          next_rsp.rdata     = (allow && !req_in.write) ?
                               mem[req_in.addr] : '0;
          do_write           = allow && req_in.write;
        end
        // level load outside an erase is refused
        next_reject = prot_set_in.valid;
      end
      flash_prot_pkg::ST_ERASE:
      begin
        // one row per cycle cleared, level back to unprotected
        // last row cleared: move on to the level load step
        if (erase_row == LAST_ROW)
        begin
          next_state = flash_prot_pkg::ST_PROG;
        end
        else
        begin
          next_erase_row = erase_row + 1'b1;
        end
        next_reject = prot_set_in.valid;
        next_rsp.valid     = req_in.valid;                // busy: refuse
        next_rsp.violation = req_in.valid;
      end
      flash_prot_pkg::ST_PROG:
      begin
        // levels may be loaded as the last step of the erase
        if (prog_done_in)
        begin
          next_state = flash_prot_pkg::ST_IDLE;
        end
        // accesses stay refused until the load step ends
        next_rsp.valid     = req_in.valid;
        next_rsp.violation = req_in.valid;
      end
      default:
      begin
        // unused code: fall back to normal accesses
        next_state = flash_prot_pkg::ST_IDLE;
      end
    endcase
    // busy covers the whole erase and level load
    next_busy      = (next_state != flash_prot_pkg::ST_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////
  // sequence registers: phase and erase walker
  // busy is a registered copy of the phase so the output comes from a flop
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      state     <= flash_prot_pkg::ST_IDLE;   // normal accesses after reset
      erase_row <= '0;                        // walker parked on row 0
      busy_out  <= 1'b0;                      // no erase after reset
    end
    else
    begin
      state     <= next_state;
      erase_row <= next_erase_row;
      busy_out  <= next_busy;                 // high in erase and load
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // security registers: internal latch and its output copy
  // the latch only ever sets; nothing but a system reset clears it
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      secured     <= 1'b0;                    // ports open after reset
      secured_out <= 1'b0;
    end
    else
    begin
      secured     <= next_secured;
      secured_out <= next_secured;            // same value, own flop
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // answer registers: one-cycle pulses towards the requester
  // both clear in reset so no stray answer or reject follows it
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      rsp_out         <= '0;
      prot_reject_out <= 1'b0;
    end
    else
    begin
      rsp_out         <= next_rsp;
      prot_reject_out <= next_reject;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // array and level storage, no reset: nonvolatile contents
  always_ff @(posedge core_clk_in)
  begin
    // only a granted write reaches the array
    if (do_write)
    begin
      mem[req_in.addr] <= req_in.wdata;
    end
    // erase clears data, ecc and level of one row a cycle
    if (state == flash_prot_pkg::ST_ERASE)
    begin
      level[erase_row] <= flash_prot_pkg::PROT_RESET;
      for (int b = 0; b < flash_prot_pkg::ROW_BYTES; b++)
      begin
        mem[{erase_row, 8'(b)}] <= '0;
      end
      for (int e = 0; e < flash_prot_pkg::ROW_ECC_BYTES; e++)
      begin
        ecc_mem[{erase_row, 5'(e)}] <= '0;
      end
    end
    // levels load only in the last step of a full erase
    if (state == flash_prot_pkg::ST_PROG && prot_set_in.valid)
    begin
      level[prot_set_in.row] <= prot_set_in.level;
    end
  end
endmodule // flash_row_protection_checker

/* File: prot_checker_sva.sv */
/*
  port assertions for the flash row protection checker.
  assumes one clock domain and the synchronous active-low reset.
*/
module prot_checker_sva (
  input wire logic                        core_clk_in,
  input wire logic                        rst_b_in,
  input wire flash_prot_pkg::access_req_t req_in,
  input wire logic                        erase_in,
  input wire flash_prot_pkg::prot_set_t   prot_set_in,
  input wire logic                        prog_done_in,
  input wire logic                        secure_in,
  input wire flash_prot_pkg::access_rsp_t rsp_out,
  input wire logic                        busy_out,
  input wire logic                        secured_out,
  input wire logic                        prot_reject_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////////////////////////
  // request taken in idle, not dropped by a starting erase
  sequence s_take;
    req_in.valid && !busy_out && !erase_in;
  endsequence
  // erase started from idle
  sequence s_erase;
    erase_in && !busy_out;
  endsequence
  AST_ANSWER: assert property (s_take |=> rsp_out.valid)
    else $error("no answer one cycle after a request");
  AST_NO_ANSWER: assert property (!req_in.valid |=> !rsp_out.valid)
    else $error("answer without a request");
  AST_ZERO: assert property (rsp_out.violation |-> rsp_out.rdata == '0)
    else $error("refused answer carries data");
  AST_BUSY_REFUSE: assert property (
    req_in.valid && busy_out |=> rsp_out.violation)
    else $error("access granted during erase phase");
  AST_STICKY: assert property (secured_out |=> secured_out)
    else $error("security dropped");
  AST_SEC_SET: assert property (secure_in |=> secured_out)
    else $error("security not engaged");
  AST_SEC_EXT: assert property (
    s_take ##0 (secured_out && req_in.external) |=> rsp_out.violation)
    else $error("external access granted while secured");
  AST_REJECT: assert property (
    prot_set_in.valid && !busy_out |=> prot_reject_out)
    else $error("level change outside erase not refused");
  AST_ERASE: assert property (s_erase |=> busy_out [*8])
    else $error("erase phase too short");
endmodule // prot_checker_sva

bind flash_row_protection_checker prot_checker_sva u_sva (
  .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .req_in(req_in),
  .erase_in(erase_in), .prot_set_in(prot_set_in),
  .prog_done_in(prog_done_in), .secure_in(secure_in), .rsp_out(rsp_out),
  .busy_out(busy_out), .secured_out(secured_out),
  .prot_reject_out(prot_reject_out));

/* File: tool_port_model.sv */
/*
  requester model: debug tool and processor side issuing byte accesses.
  assumes the answer is registered on the taking edge itself.
*/
module tool_port_model (
  input  wire logic                        clk_in,
  input  wire flash_prot_pkg::access_rsp_t rsp_in,
  output flash_prot_pkg::access_req_t      req_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial req_out = '0;
  ////////////////////////////////////////////////////////////
  // raise after an edge, hold to the taking edge, take the answer
  task automatic access(input logic ext, wr, input logic [15:0] a,
    input logic [7:0] wd, output flash_prot_pkg::access_rsp_t r);
    @(posedge clk_in);
    #1 req_out = {1'b1, ext, wr, a, wd};
    @(posedge clk_in);
    #1 r = rsp_in;
    // released lines show inverted values, never stale ones
    req_out = {1'b0, ~req_out[$bits(req_out)-2:0]};
  endtask
endmodule // tool_port_model

/* File: tb_top.sv */
/*
  self-checking bench for the flash row protection checker.
  assumes the requester model and the bound port checker.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_in, rst_b_in, erase_in, prog_done_in, secure_in;
  logic busy_out, secured_out, prot_reject_out;
  flash_prot_pkg::access_req_t req_in;
  flash_prot_pkg::access_rsp_t rsp_out, r;
  flash_prot_pkg::prot_set_t   prot_set_in;
  int miscompares = 0;
  int n_compared = 0;
  flash_row_protection_checker u_dut (.core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in), .req_in(req_in), .erase_in(erase_in),
    .prot_set_in(prot_set_in), .prog_done_in(prog_done_in),
    .secure_in(secure_in), .rsp_out(rsp_out), .busy_out(busy_out),
    .secured_out(secured_out), .prot_reject_out(prot_reject_out));
  tool_port_model u_tool (.clk_in(core_clk_in), .rsp_in(rsp_out),
    .req_out(req_in));
  initial
  begin
    core_clk_in = 0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // expected grant from level, source, direction and security
  function automatic logic ok(input logic [1:0] l, input logic e, w, s);
    return !(e && s) && (l == 2'h0 || (l == 2'h1 && !(e && !w))
      || (l == 2'h2 && !e) || (l == 2'h3 && !e && !w));
  endfunction
  task automatic scen_erase_load;
    @(posedge core_clk_in);
    #1 erase_in = 1;
    @(posedge core_clk_in);
    #1 erase_in = 0;
    chk(busy_out, 1'b1);
    u_tool.access(1'b0, 1'b0, 16'h0000, 8'h00, r);
    chk(r.violation, 1'b1);
    // a level load while rows are still being cleared must bounce
    @(posedge core_clk_in);
    #1 prot_set_in = {1'b1, 8'h04, flash_prot_pkg::PROT_FULL};
    @(posedge core_clk_in);
    #1 prot_set_in.valid = 1'b0;
    chk(prot_reject_out, 1'b1);
    repeat (260) @(posedge core_clk_in);
    // rows 0..3 get codes 0..3
    for (int i = 0; i < 4; i++)
    begin
      #1 prot_set_in = {1'b1, 8'(i), flash_prot_pkg::prot_level_t'(i)};
      @(posedge core_clk_in);
    end
    #1 prot_set_in.valid = 0;
    prog_done_in = 1;
    @(posedge core_clk_in);
    #1 prog_done_in = 0;
    repeat (2) @(posedge core_clk_in);
    #1 chk(busy_out, 1'b0);
  endtask
  // k: 0 internal write, 1 external write, 2 external read, 3 internal read
  task automatic scen_levels;
    logic [7:0] want, wd;
    logic       ex, wr, e;
    // row 4 was never loaded and keeps the erased, unprotected level
    for (int row = 0; row < 5; row++)
    begin
      // every row was erased to zero, so reads are checked from the start
      want = 8'h00;
      for (int k = 0; k < 4; k++)
      begin
        ex = k inside {1, 2};
        wr = k < 2;
        wd = 8'h50 + 8'(row * 16 + k);
        e = ok(row < 4 ? 2'(row) : 2'h0, ex, wr, 1'b0);
        u_tool.access(ex, wr, {8'(row), 8'h07}, wd, r);
        chk(r.violation, !e);
        if (wr && e)
        begin
          want = wd;
        end
        if (!wr)
        begin
          chk(r.rdata, e ? want : 8'h00);
        end
      end
    end
  endtask
  task automatic scen_reject;
    @(posedge core_clk_in);
    #1 prot_set_in = {1'b1, 8'h00, flash_prot_pkg::PROT_FULL};
    @(posedge core_clk_in);
    #1 prot_set_in.valid = 0;
    chk(prot_reject_out, 1'b1);
    u_tool.access(1'b1, 1'b0, 16'h0007, 8'h00, r);
    chk(r.rdata, 8'h51);
  endtask
  task automatic scen_secure;
    @(posedge core_clk_in);
    #1 secure_in = 1;
    @(posedge core_clk_in);
    #1 secure_in = 0;
    chk(secured_out, 1'b1);
    u_tool.access(1'b1, 1'b0, 16'h0007, 8'h00, r);
    chk(r.violation, 1'b1);
    u_tool.access(1'b0, 1'b0, 16'h0007, 8'h00, r);
    chk(r.rdata, 8'h51);
  endtask
  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    rst_b_in = 0;
    erase_in = 0;
    prog_done_in = 0;
    secure_in = 0;
    prot_set_in = '0;
    repeat (3) @(posedge core_clk_in);
    #1 rst_b_in = 1;
    scen_erase_load();
    scen_levels();
    scen_reject();
    scen_secure();
    complete_run();
  end
  // watchdog: the run needs well under 600 cycles
  initial
  begin
    #20000;
    miscompares++;
    complete_run();
  end
endmodule // tb_top
